//--- common/sbem_pkg.sv
// constants and types for the serial bit mismatch monitor
package sbem_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CFG      = 12'h00b1;
   localparam logic [11:0] IDX_EXT      = 12'h00b2;
   localparam logic [11:0] ADDR_CFG     = 12'(IDX_CFG * 4);
   localparam logic [11:0] ADDR_EXT     = 12'(IDX_EXT * 4);

   localparam logic [7:0]  CFG_RESET    = 8'h00;
   localparam logic [7:0]  EXT_RESET    = 8'h00;

   // base configuration fields
   localparam int          CFG_EN       = 7;

   // extended configuration fields
   localparam int          EXT_ACTIVE   = 7;
   localparam int          EXT_FLAG     = 6;
   localparam int          EXT_TX_ABORT = 5;
   localparam int          EXT_RX_ABORT = 4;
   localparam int          EXT_LOOPBACK = 3;
   localparam int          EXT_IRQ_EN   = 2;
   localparam int          EXT_FLUSH    = 1;
   localparam int          EXT_TX_POL   = 0;

   // bit timing at 40 MHz
   localparam int          CLK_HZ       = 40_000_000;
   localparam int          BAUD_HZ      = 115_200;
   localparam logic [15:0] BIT_CYC      = 16'(CLK_HZ / BAUD_HZ);
   localparam logic [15:0] BIT_HALF     = 16'(CLK_HZ / BAUD_HZ / 2);
   localparam logic [15:0] CNT_ZERO     = 16'h0000;

   localparam int          DATA_BITS    = 8;
   localparam int          FIFO_DEPTH   = 4;
   localparam logic [2:0]  PTR_ZERO     = 3'h0;
   localparam logic [2:0]  LAST_BIT     = 3'h7;

   typedef enum logic [1:0] {
      SB_IDLE  = 2'b00,
      SB_START = 2'b01,
      SB_DATA  = 2'b10,
      SB_STOP  = 2'b11
   } sbem_state_t;

endpackage : sbem_pkg

//--- design/sbem_top.sv
// serial port with bit mismatch monitor, loopback and flush controls
`timescale 1ns/100ps
module sbem_top
   import sbem_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_data_valid,
   output logic             tx_data_ready,
   output logic      [7:0]  rx_data,
   output logic             rx_data_valid,
   input  wire logic        rx_data_ready,
   input  wire logic        rxd,
   output logic             txd,
   output logic             mismatch_irq
);

   // bus side
   logic        setup;
   logic        wr;
   logic        hit_cfg;
   logic        hit_ext;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // registers
   logic [7:0]  cfg_reg;
   logic [7:0]  cfg_next;
   logic        active_reg;
   logic        active_next;
   logic        flag_reg;
   logic        flag_next;
   logic        txab_reg;
   logic        txab_next;
   logic        rxab_reg;
   logic        rxab_next;
   logic        lbk_reg;
   logic        lbk_next;
   logic        irqen_reg;
   logic        irqen_next;
   logic        pol_reg;
   logic        pol_next;
   logic        flush_reg;
   logic        flush_next;
   logic [7:0]  ext_rd;

   // line side
   logic        rxd_s1;
   logic        rxd_s2;
   logic        rx_in;
   logic        mis_set;
   logic        kill_tx;
   logic        kill_rx;

   // transmit path
   logic [7:0]  tx_mem      [FIFO_DEPTH];
   logic [7:0]  tx_mem_next [FIFO_DEPTH];
   logic [2:0]  tx_wp;
   logic [2:0]  tx_wp_next;
   logic [2:0]  tx_rp;
   logic [2:0]  tx_rp_next;
   logic        tx_full;
   logic        tx_empty;
   logic        tx_push;
   logic        tx_pop;
   sbem_state_t tx_state;
   sbem_state_t tx_state_next;
   logic [15:0] tx_cnt;
   logic [15:0] tx_cnt_next;
   logic [2:0]  tx_idx;
   logic [2:0]  tx_idx_next;
   logic [7:0]  tx_sh;
   logic [7:0]  tx_sh_next;
   logic        tx_bit;
   logic        txd_reg;
   logic        txd_next;

   // receive path
   logic [7:0]  rx_mem      [FIFO_DEPTH];
   logic [7:0]  rx_mem_next [FIFO_DEPTH];
   logic [2:0]  rx_wp;
   logic [2:0]  rx_wp_next;
   logic [2:0]  rx_rp;
   logic [2:0]  rx_rp_next;
   logic        rx_full;
   logic        rx_empty;
   logic        rx_push;
   logic        rx_pop;
   sbem_state_t rx_state;
   sbem_state_t rx_state_next;
   logic [15:0] rx_cnt;
   logic [15:0] rx_cnt_next;
   logic [2:0]  rx_idx;
   logic [2:0]  rx_idx_next;
   logic [7:0]  rx_sh;
   logic [7:0]  rx_sh_next;

   // ---------------- bus slave ----------------
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign hit_cfg = (paddr == ADDR_CFG);
   assign hit_ext = (paddr == ADDR_EXT);
   // zero wait states: read data is captured during the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~(hit_cfg | hit_ext);
   assign prdata  = prdata_reg;

   always_comb begin
      ext_rd               = 8'h00;
      ext_rd[EXT_ACTIVE]   = active_reg;
      ext_rd[EXT_FLAG]     = flag_reg;
      ext_rd[EXT_TX_ABORT] = txab_reg;
      ext_rd[EXT_RX_ABORT] = rxab_reg;
      ext_rd[EXT_LOOPBACK] = lbk_reg;
      ext_rd[EXT_IRQ_EN]   = irqen_reg;
      ext_rd[EXT_TX_POL]   = pol_reg;
      prdata_next          = prdata_reg;
      if (setup) begin
         if (hit_cfg) begin
            prdata_next = {24'h00_0000, cfg_reg};
         end else if (hit_ext) begin
            prdata_next = {24'h00_0000, ext_rd};
         end else begin
            prdata_next = 32'h0000_0000;
         end
      end
   end

   // ---------------- control registers ----------------
   always_comb begin
      cfg_next    = cfg_reg;
      txab_next   = txab_reg;
      rxab_next   = rxab_reg;
      lbk_next    = lbk_reg;
      irqen_next  = irqen_reg;
      pol_next    = pol_reg;
      flush_next  = 1'b0;
      flag_next   = flag_reg;
      active_next = active_reg;
      if (wr && hit_cfg) begin
         cfg_next = pwdata[7:0];
      end
      if (wr && hit_ext) begin
         txab_next  = pwdata[EXT_TX_ABORT];
         rxab_next  = pwdata[EXT_RX_ABORT];
         lbk_next   = pwdata[EXT_LOOPBACK];
         irqen_next = pwdata[EXT_IRQ_EN];
         pol_next   = pwdata[EXT_TX_POL];
         flush_next = pwdata[EXT_FLUSH];
         // only a written zero clears; hardware never does
         if (!pwdata[EXT_FLAG]) begin
            flag_next = 1'b0;
         end
      end
      // a mismatch in the clearing cycle still lands
      if (mis_set) begin
         flag_next = 1'b1;
      end
      if (rx_state == SB_IDLE && rx_state_next == SB_START) begin
         active_next = 1'b1;
      end else if (rx_state_next == SB_IDLE) begin
         active_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         cfg_reg    <= CFG_RESET;
         active_reg <= EXT_RESET[EXT_ACTIVE];
         flag_reg   <= EXT_RESET[EXT_FLAG];
         txab_reg   <= EXT_RESET[EXT_TX_ABORT];
         rxab_reg   <= EXT_RESET[EXT_RX_ABORT];
         lbk_reg    <= EXT_RESET[EXT_LOOPBACK];
         irqen_reg  <= EXT_RESET[EXT_IRQ_EN];
         pol_reg    <= EXT_RESET[EXT_TX_POL];
         flush_reg  <= EXT_RESET[EXT_FLUSH];
      end else begin
         prdata_reg <= prdata_next;
         cfg_reg    <= cfg_next;
         active_reg <= active_next;
         flag_reg   <= flag_next;
         txab_reg   <= txab_next;
         rxab_reg   <= rxab_next;
         lbk_reg    <= lbk_next;
         irqen_reg  <= irqen_next;
         pol_reg    <= pol_next;
         flush_reg  <= flush_next;
      end
   end

   assign mismatch_irq = flag_reg & irqen_reg;

   // ---------------- line and mismatch ----------------
   assign rx_in   = lbk_reg ? txd_reg : rxd_s2;
   assign txd     = txd_reg;
   // mid bit, same offset the receiver samples at
   assign mis_set = (tx_state != SB_IDLE) && (tx_cnt == BIT_HALF)
                    && (rx_in != txd_reg);
   assign kill_tx = flush_reg | (mis_set & txab_reg);
   assign kill_rx = flush_reg | (mis_set & rxab_reg);

   // ---------------- fifos ----------------
   assign tx_full  = (tx_wp[2] != tx_rp[2]) && (tx_wp[1:0] == tx_rp[1:0]);
   assign tx_empty = (tx_wp == tx_rp);
   assign tx_data_ready = ~tx_full & ~kill_tx;
   assign tx_push  = tx_data_valid & tx_data_ready;
   assign tx_pop   = (tx_state == SB_IDLE) & cfg_reg[CFG_EN] & ~tx_empty
                     & ~kill_tx;
   assign rx_full  = (rx_wp[2] != rx_rp[2]) && (rx_wp[1:0] == rx_rp[1:0]);
   assign rx_empty = (rx_wp == rx_rp);
   assign rx_data_valid = ~rx_empty;
   assign rx_data  = rx_mem[rx_rp[1:0]];
   assign rx_pop   = rx_data_valid & rx_data_ready;

   genvar g;
   generate
      for (g = 0; g < FIFO_DEPTH; g++) begin : g_entry
         assign tx_mem_next[g] = (tx_push && tx_wp[1:0] == 2'(g))
                                 ? tx_data : tx_mem[g];
         assign rx_mem_next[g] = (rx_push && rx_wp[1:0] == 2'(g))
                                 ? rx_sh_next : rx_mem[g];
      end
   endgenerate

   // ---------------- transmitter ----------------
   always_comb begin
      tx_state_next = tx_state;
      tx_cnt_next   = tx_cnt + 16'h0001;
      tx_idx_next   = tx_idx;
      tx_sh_next    = tx_sh;
      tx_wp_next    = tx_push ? tx_wp + 3'h1 : tx_wp;
      tx_rp_next    = tx_pop ? tx_rp + 3'h1 : tx_rp;
      tx_bit        = 1'b1;
      case (tx_state)
         SB_IDLE: begin
            tx_cnt_next = CNT_ZERO;
            if (tx_pop) begin
               tx_sh_next    = tx_mem[tx_rp[1:0]];
               tx_state_next = SB_START;
            end
         end
         SB_START: begin
            tx_bit = 1'b0;
            if (tx_cnt == BIT_CYC - 16'h0001) begin
               tx_cnt_next   = CNT_ZERO;
               tx_idx_next   = PTR_ZERO;
               tx_state_next = SB_DATA;
            end
         end
         SB_DATA: begin
            tx_bit = tx_sh[0];
            if (tx_cnt == BIT_CYC - 16'h0001) begin
               tx_cnt_next = CNT_ZERO;
               tx_sh_next  = {1'b1, tx_sh[7:1]};
               tx_idx_next = tx_idx + 3'h1;
               if (tx_idx == LAST_BIT) begin
                  tx_state_next = SB_STOP;
               end
            end
         end
         SB_STOP: begin
            if (tx_cnt == BIT_CYC - 16'h0001) begin
               tx_state_next = SB_IDLE;
            end
         end
         default: begin
            tx_state_next = SB_IDLE;
         end
      endcase
      // abort or flush wins over any frame in flight
      if (kill_tx) begin
         tx_state_next = SB_IDLE;
         tx_cnt_next   = CNT_ZERO;
         tx_wp_next    = PTR_ZERO;
         tx_rp_next    = PTR_ZERO;
         tx_bit        = 1'b1;
      end
      txd_next = tx_bit ^ pol_reg;
   end

   // ---------------- receiver ----------------
   always_comb begin
      rx_state_next = rx_state;
      rx_cnt_next   = rx_cnt + 16'h0001;
      rx_idx_next   = rx_idx;
      rx_sh_next    = rx_sh;
      rx_push       = 1'b0;
      rx_wp_next    = rx_wp;
      rx_rp_next    = rx_pop ? rx_rp + 3'h1 : rx_rp;
      case (rx_state)
         SB_IDLE: begin
            rx_cnt_next = CNT_ZERO;
            // polarity applies to the line, so idle follows it
            if (cfg_reg[CFG_EN] && (rx_in == pol_reg)) begin
               rx_state_next = SB_START;
            end
         end
         SB_START: begin
            if (rx_cnt == BIT_HALF) begin
               rx_cnt_next = CNT_ZERO;
               rx_idx_next = PTR_ZERO;
               // glitch shorter than half a bit is dropped
               rx_state_next = (rx_in == pol_reg) ? SB_DATA : SB_IDLE;
            end
         end
         SB_DATA: begin
            if (rx_cnt == BIT_CYC - 16'h0001) begin
               rx_cnt_next = CNT_ZERO;
               rx_sh_next  = {rx_in ^ pol_reg, rx_sh[7:1]};
               rx_idx_next = rx_idx + 3'h1;
               if (rx_idx == LAST_BIT) begin
                  rx_state_next = SB_STOP;
               end
            end
         end
         SB_STOP: begin
            if (rx_cnt == BIT_CYC - 16'h0001) begin
               rx_state_next = SB_IDLE;
               // full fifo drops the byte
               rx_push    = ~rx_full;
               rx_wp_next = rx_full ? rx_wp : rx_wp + 3'h1;
            end
         end
         default: begin
            rx_state_next = SB_IDLE;
         end
      endcase
      if (kill_rx) begin
         rx_state_next = SB_IDLE;
         rx_cnt_next   = CNT_ZERO;
         rx_push       = 1'b0;
         rx_wp_next    = PTR_ZERO;
         rx_rp_next    = PTR_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_s1   <= 1'b1;
         rxd_s2   <= 1'b1;
         txd_reg  <= 1'b1;
         tx_state <= SB_IDLE;
         tx_cnt   <= CNT_ZERO;
         tx_idx   <= PTR_ZERO;
         tx_sh    <= 8'h00;
         tx_wp    <= PTR_ZERO;
         tx_rp    <= PTR_ZERO;
         tx_mem   <= '{default: 8'h00};
         rx_state <= SB_IDLE;
         rx_cnt   <= CNT_ZERO;
         rx_idx   <= PTR_ZERO;
         rx_sh    <= 8'h00;
         rx_wp    <= PTR_ZERO;
         rx_rp    <= PTR_ZERO;
         rx_mem   <= '{default: 8'h00};
      end else begin
         rxd_s1   <= rxd;
         rxd_s2   <= rxd_s1;
         txd_reg  <= txd_next;
         tx_state <= tx_state_next;
         tx_cnt   <= tx_cnt_next;
         tx_idx   <= tx_idx_next;
         tx_sh    <= tx_sh_next;
         tx_wp    <= tx_wp_next;
         tx_rp    <= tx_rp_next;
         tx_mem   <= tx_mem_next;
         rx_state <= rx_state_next;
         rx_cnt   <= rx_cnt_next;
         rx_idx   <= rx_idx_next;
         rx_sh    <= rx_sh_next;
         rx_wp    <= rx_wp_next;
         rx_rp    <= rx_rp_next;
         rx_mem   <= rx_mem_next;
      end
   end

endmodule : sbem_top

//--- dv/sbem_properties.sv
// port checker for the serial bit mismatch monitor
`timescale 1ns/100ps
module sbem_checker
   import sbem_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        tx_data_ready,
   input wire logic        rx_data_valid,
   input wire logic        txd,
   input wire logic        mismatch_irq
);
   logic       acc;
   logic       ext_wr;
   logic [3:0] sh_reg;
   assign acc = psel && penable;
   assign ext_wr = acc && pwrite && paddr == ADDR_EXT;
   // shadow of irq enable, tx abort, rx abort, polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 4'h0;
      end else if (ext_wr) begin
         sh_reg <= {pwdata[EXT_IRQ_EN], pwdata[EXT_TX_ABORT],
                    pwdata[EXT_RX_ABORT], pwdata[EXT_TX_POL]};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (acc |->
      pslverr == (paddr != ADDR_CFG && paddr != ADDR_EXT))
      else $error("pslverr does not match address");
   a_upper_zero: assert property (prdata[31:8] == '0)
      else $error("prdata upper bits not zero");
   a_reset_idle: assert property ($rose(presetn) |->
      txd && !mismatch_irq && !rx_data_valid)
      else $error("outputs not idle after reset");
   a_flag_sticky: assert property ($fell(mismatch_irq) |->
      $past(ext_wr)) else $error("irq fell without a write");
   a_irq_gated: assert property (mismatch_irq |-> sh_reg[3])
      else $error("irq high while disabled");
   a_flush_clears: assert property (ext_wr && pwdata[EXT_FLUSH] |=>
      !tx_data_ready ##1 !rx_data_valid) else $error("flush missing");
   a_tx_abort: assert property (sh_reg[3] && sh_reg[2] &&
      $rose(mismatch_irq) |-> ##[0:2] (txd == !sh_reg[0]))
      else $error("tx not aborted");
   a_rx_abort: assert property (sh_reg[3] && sh_reg[1] &&
      $rose(mismatch_irq) |-> ##[0:2] !rx_data_valid)
      else $error("rx not aborted");
   c_irq: cover property ($rose(mismatch_irq));
   c_flush: cover property (ext_wr && pwdata[EXT_FLUSH]);
   c_err: cover property (acc && pslverr);
endmodule : sbem_checker

//--- dv/sbem_line_model.sv
// serial line partner: reads the transmit line back onto receive
`timescale 1ns/100ps
module sbem_line_model
(
   input  wire logic pclk,
   input  wire logic txd,
   input  wire logic corrupt,
   input  wire logic tx_pin_on,
   output logic      rxd
);
   // read-back lags one cycle; corrupt models a bus collision
   // pin function off: transmitter cut from the pin, pull-up holds it high
   always_ff @(posedge pclk) begin
      if (!tx_pin_on) begin
         rxd <= 1'b1;
      end else begin
         rxd <= corrupt ? !txd : txd;
      end
   end
endmodule : sbem_line_model

//--- dv/test_serial_bit_error_monitor.sv
// testbench for the serial bit mismatch monitor
`timescale 1ns/100ps
module test_serial_bit_error_monitor;
   import sbem_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, er, txd, rxd, mismatch_irq, corrupt = 0;
   logic [7:0]  tx_data = '0, rx_data;
   logic        tx_data_valid = 0, tx_data_ready, rx_data_valid;
   logic        rx_data_ready = 0;
   logic        tx_pin_on = 1;
   int          err_total = 0, n_tests = 0, cyc = 0;

   always #12.5 pclk = ~pclk;

   sbem_top i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_data(tx_data), .tx_data_valid(tx_data_valid),
      .tx_data_ready(tx_data_ready), .rx_data(rx_data),
      .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready),
      .rxd(rxd), .txd(txd), .mismatch_irq(mismatch_irq));
   sbem_line_model i_line(.pclk(pclk), .txd(txd), .corrupt(corrupt),
      .tx_pin_on(tx_pin_on), .rxd(rxd));

   task wrap_up;
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   // about seventeen frames of work; far above the expected run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         wrap_up();
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task chk_ext(input logic [7:0] m, input logic [7:0] e, input string nm);
      apb(0, ADDR_EXT, 32'h0000_0000);
      chk(nm, rd & {24'h00_0000, m}, {24'h00_0000, e});
   endtask : chk_ext

   task push(input logic [7:0] b);
      @(posedge pclk);
      tx_data <= b;
      tx_data_valid <= 1;
      @(posedge pclk);
      while (tx_data_ready !== 1'b1) @(posedge pclk);
      tx_data_valid <= 0;
   endtask : push

   task t_regs;
      apb(0, ADDR_CFG, 32'h0000_0000);
      chk("cfg reset", rd, 32'h0000_0000);
      chk_ext(8'hff, 8'h00, "ext reset");
      apb(1, 12'h0ffc, 32'h0000_00ff);
      chk("unmapped err", er, 1'b1);
      apb(0, 12'h0ffc, 32'h0000_0000);
      chk("unmapped read", rd, 32'h0000_0000);
      apb(1, ADDR_EXT, 32'h0000_0080);
      chk_ext(8'hff, 8'h00, "status read only");
      apb(1, ADDR_CFG, 32'h0000_0080);
      apb(0, ADDR_CFG, 32'h0000_0000);
      chk("cfg rw", rd, 32'h0000_0080);
   endtask : t_regs

   task t_loop;
      // pin function off before loopback; the pin then idles high
      tx_pin_on <= 0;
      apb(1, ADDR_EXT, 32'h0000_0008);
      push(8'ha5);
      // lands well inside the frame
      repeat (2000) @(posedge pclk);
      chk_ext(8'h80, 8'h80, "rx active");
      while (rx_data_valid !== 1'b1) @(posedge pclk);
      chk("loop data", rx_data, 8'ha5);
      chk_ext(8'h40, 8'h00, "no mismatch");
   endtask : t_loop

   task t_flush;
      chk("rx held", rx_data_valid, 1'b1);
      apb(1, ADDR_EXT, 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk("flush rx", rx_data_valid, 1'b0);
      chk_ext(8'h02, 8'h00, "flush self clear");
   endtask : t_flush

   task t_txabort;
      tx_pin_on <= 1;
      apb(1, ADDR_EXT, 32'h0000_0024);
      corrupt <= 1;
      repeat (1000) @(posedge pclk);
      chk_ext(8'h40, 8'h00, "idle no compare");
      push(8'h3c);
      // queued byte must be thrown away by the abort, not sent next
      push(8'hc3);
      while (mismatch_irq !== 1'b1) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk("tx aborted", txd, 1'b1);
      chk_ext(8'h40, 8'h40, "flag set");
      apb(1, ADDR_EXT, 32'h0000_0060);
      chk_ext(8'h40, 8'h40, "flag sticky");
      chk("irq masked", mismatch_irq, 1'b0);
      apb(1, ADDR_EXT, 32'h0000_0000);
      chk_ext(8'h40, 8'h00, "flag cleared");
      corrupt <= 0;
   endtask : t_txabort

   task t_rxabort;
      tx_pin_on <= 0;
      apb(1, ADDR_EXT, 32'h0000_000a);
      push(8'h5a);
      while (rx_data_valid !== 1'b1) @(posedge pclk);
      chk("loop again", rx_data, 8'h5a);
      tx_pin_on <= 1;
      apb(1, ADDR_EXT, 32'h0000_0014);
      corrupt <= 1;
      push(8'h99);
      while (mismatch_irq !== 1'b1) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk("rx aborted", rx_data_valid, 1'b0);
      corrupt <= 0;
      apb(1, ADDR_EXT, 32'h0000_0002);
   endtask : t_rxabort

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_loop();
      t_flush();
      t_txabort();
      t_rxabort();
      wrap_up();
   end
endmodule : test_serial_bit_error_monitor

bind sbem_top sbem_checker i_chk(.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .tx_data_ready(tx_data_ready), .rx_data_valid(rx_data_valid),
   .txd(txd), .mismatch_irq(mismatch_irq));
